// file: src/daw_pkg.sv
// Constants shared by the diagnostic flag block and its helpers.
// Assumes byte-wide registers placed one per 32-bit word on the bus.
package daw_pkg;

	// ------------------------------------------------------------------
	// Register indices; the bus byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_THR_LAST = 8'h27;
	localparam logic [7:0] IDX_RT_FIRST = 8'h60;
	localparam logic [7:0] IDX_RT_LAST = 8'h69;
	localparam logic [7:0] IDX_CTRL = 8'h6e;
	localparam logic [7:0] IDX_ALM_P = 8'h70;
	localparam logic [7:0] IDX_ALM_R = 8'h71;
	localparam logic [7:0] IDX_WRN_P = 8'h74;
	localparam logic [7:0] IDX_WRN_R = 8'h75;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hf8;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hf9;

	// ------------------------------------------------------------------
	// Status/control byte fields
	// ------------------------------------------------------------------
	localparam int CTL_PIN_DIS = 7;
	localparam int CTL_SOFT_DIS = 6;
	localparam int CTL_RATE = 4;
	localparam int CTL_FAULT = 2;
	localparam int CTL_LOS = 1;
	localparam int CTL_NRDY = 0;

	// ------------------------------------------------------------------
	// Threshold layout: each quantity owns eight bytes, MSB first
	// ------------------------------------------------------------------
	localparam int NUM_Q = 5;
	localparam int THR_STRIDE = 8;
	localparam int THR_HA = 0;
	localparam int THR_LA = 2;
	localparam int THR_HW = 4;
	localparam int THR_LW = 6;
	localparam int Q_TEMP = 0;
	localparam int Q_RXP = 4;
	localparam int RX_RSV_W = 6;

	// ------------------------------------------------------------------
	// Reset values and interrupt layout
	// ------------------------------------------------------------------
	localparam logic [7:0] THR_RST = 8'h00;
	localparam logic [15:0] RT_RST = 16'h0000;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;
	localparam logic SOFT_DIS_RST = 1'b0;
	localparam int IRQ_W = 3;
	localparam int IRQ_ALM = 0;
	localparam int IRQ_WRN = 1;
	localparam int IRQ_UPD = 2;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} daw_bus_e;

endpackage

// file: src/daw_cmp.sv
// Window comparator for one monitored quantity against four thresholds.
// Assumes all inputs are stable registers; outputs are combinational.
`timescale 1ns/1ps
module daw_cmp #(
	parameter bit IS_SIGNED = 1'b0
) (
	// Value and thresholds
	input wire logic [15:0] val_i,
	input wire logic [15:0] ha_i,
	input wire logic [15:0] la_i,
	input wire logic [15:0] hw_i,
	input wire logic [15:0] lw_i,
	// Results
	output logic ha_o,
	output logic la_o,
	output logic hw_o,
	output logic lw_o
);
	// Flipping the sign bit turns a two's complement compare into an
	// unsigned one, so one comparator serves both kinds of quantity.
	wire [15:0] flip = {IS_SIGNED, 15'h0000};
	wire [15:0] v = val_i ^ flip;

	assign ha_o = v > (ha_i ^ flip);
	assign la_o = v < (la_i ^ flip);
	assign hw_o = v > (hw_i ^ flip);
	assign lw_o = v < (lw_i ^ flip);
endmodule

// file: src/daw_irq.sv
// Sticky event status with write-one-to-clear, a mask and a level output.
// Assumes write strobes are single-cycle and come from the bus slave.
`timescale 1ns/1ps
module daw_irq (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Events and register access
	input wire logic [daw_pkg::IRQ_W-1:0] evt_i,
	input wire logic wr_stat_i,
	input wire logic wr_mask_i,
	input wire logic [7:0] wdata_i,
	// State
	output logic [daw_pkg::IRQ_W-1:0] stat_o,
	output logic [daw_pkg::IRQ_W-1:0] mask_o,
	output logic irq_o
);
	logic [daw_pkg::IRQ_W-1:0] stat_ff;
	logic [daw_pkg::IRQ_W-1:0] mask_ff;
	wire [daw_pkg::IRQ_W-1:0] clr = wr_stat_i ? wdata_i[daw_pkg::IRQ_W-1:0] : '0;
	// A new event wins over a clear landing in the same cycle.
	wire [daw_pkg::IRQ_W-1:0] nxt_stat = (stat_ff & ~clr) | evt_i;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stat_ff <= '0;
			mask_ff <= daw_pkg::IRQ_MASK_RST[daw_pkg::IRQ_W-1:0];
		end else begin
			stat_ff <= nxt_stat;
			if (wr_mask_i) begin
				mask_ff <= wdata_i[daw_pkg::IRQ_W-1:0];
			end
		end
	end

	assign stat_o = stat_ff;
	assign mask_o = mask_ff;
	assign irq_o = |(stat_ff & mask_ff);
endmodule

// file: src/daw_flags.sv
// Diagnostic alarm and warning flag block with its register slave.
// Assumes an Avalon-MM master on sys_clk_i and measurements that arrive
// as a set of five values with a one-cycle update strobe.
//
// What this block does
// - Transmitter is off when soft disable bit or disable pin is set.
// - Rate select pin never changes behaviour; receiver stays at full bandwidth.
// - Alarm byte bit 7 set while temperature is above its high alarm.
// - Alarm byte bit 6 set while temperature is below its low alarm.
// - Alarm bits 5 and 4 report supply voltage above high, below low.
// - Alarm bits 3 and 2 report laser bias above high, below low.
// - Alarm bits 1 and 0 report transmit power above high, below low.
// - Receive alarm byte: bit 7 high, bit 6 low, bits 5..0 zero.
// - Warning byte bits 7 and 6 report temperature high and low.
// - Warning bits 5 and 4 report supply voltage high and low.
// - Warning bits 3 and 2 report laser bias high and low.
// - Warning bits 1 and 0 report transmit power high and low.
// - Receive warning byte: bit 7 high, bit 6 low, bits 5..0 zero.
// - Values and thresholds are 16 bits, MSB byte first; temperature signed.
// - Soft transmit-disable bit of the control byte is readable and writable.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module daw_flags (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Avalon-MM slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Measurements
	input wire logic meas_upd_i,
	input wire logic [15:0] meas_temp_i,
	input wire logic [15:0] meas_vcc_i,
	input wire logic [15:0] meas_bias_i,
	input wire logic [15:0] meas_txp_i,
	input wire logic [15:0] meas_rxp_i,
	// Module pins
	input wire logic tx_dis_pin_i,
	input wire logic rate_sel_i,
	input wire logic tx_fault_i,
	input wire logic rx_los_i,
	output logic tx_off_o,
	output logic rx_full_bw_o,
	output logic irq_o
);
	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [7:0] thr_ff [0:daw_pkg::IDX_THR_LAST];
	logic [15:0] rt_ff [0:daw_pkg::NUM_Q-1];
	logic soft_dis_ff;
	logic nrdy_ff;
	logic tx_off_ff;
	logic [7:0] alm_p_ff;
	logic [1:0] alm_r_ff;
	logic [7:0] wrn_p_ff;
	logic [1:0] wrn_r_ff;
	logic [31:0] rdata_ff;
	daw_pkg::daw_bus_e bus_ff;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire [7:0] idx = avs_address_i[9:2];
	wire req = avs_read_i | avs_write_i;
	wire in_ack = bus_ff == daw_pkg::BUS_ACK;
	wire wr_go = avs_write_i & in_ack & avs_byteenable_i[0];
	wire [7:0] wdata = avs_writedata_i[7:0];
	wire hit_thr = idx <= daw_pkg::IDX_THR_LAST;
	wire hit_rt = (idx >= daw_pkg::IDX_RT_FIRST) && (idx <= daw_pkg::IDX_RT_LAST);
	wire wr_thr = wr_go & hit_thr;
	wire wr_ctrl = wr_go & (idx == daw_pkg::IDX_CTRL);
	wire wr_istat = wr_go & (idx == daw_pkg::IDX_IRQ_STAT);
	wire wr_imask = wr_go & (idx == daw_pkg::IDX_IRQ_MASK);
	wire [daw_pkg::NUM_Q-1:0] nxt_ha;
	wire [daw_pkg::NUM_Q-1:0] nxt_la;
	wire [daw_pkg::NUM_Q-1:0] nxt_hw;
	wire [daw_pkg::NUM_Q-1:0] nxt_lw;
	wire [daw_pkg::IRQ_W-1:0] istat;
	wire [daw_pkg::IRQ_W-1:0] imask;

	assign avs_waitrequest_o = req & ~in_ack;

	// ------------------------------------------------------------------
	// Comparators, one per monitored quantity
	// ------------------------------------------------------------------
	genvar q;
	generate
		for (q = 0; q < daw_pkg::NUM_Q; q++) begin : g_q
			localparam int B = q * daw_pkg::THR_STRIDE;
			daw_cmp #(
				.IS_SIGNED(q == daw_pkg::Q_TEMP)
			) u_cmp (
				.val_i(rt_ff[q]),
				.ha_i({thr_ff[B + daw_pkg::THR_HA], thr_ff[B + daw_pkg::THR_HA + 1]}),
				.la_i({thr_ff[B + daw_pkg::THR_LA], thr_ff[B + daw_pkg::THR_LA + 1]}),
				.hw_i({thr_ff[B + daw_pkg::THR_HW], thr_ff[B + daw_pkg::THR_HW + 1]}),
				.lw_i({thr_ff[B + daw_pkg::THR_LW], thr_ff[B + daw_pkg::THR_LW + 1]}),
				.ha_o(nxt_ha[q]),
				.la_o(nxt_la[q]),
				.hw_o(nxt_hw[q]),
				.lw_o(nxt_lw[q])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Flag packing
	// ------------------------------------------------------------------
	wire [7:0] nxt_alm_p = {nxt_ha[0], nxt_la[0], nxt_ha[1], nxt_la[1],
		nxt_ha[2], nxt_la[2], nxt_ha[3], nxt_la[3]};
	wire [7:0] nxt_wrn_p = {nxt_hw[0], nxt_lw[0], nxt_hw[1], nxt_lw[1],
		nxt_hw[2], nxt_lw[2], nxt_hw[3], nxt_lw[3]};
	wire [1:0] nxt_alm_r = {nxt_ha[daw_pkg::Q_RXP], nxt_la[daw_pkg::Q_RXP]};
	wire [1:0] nxt_wrn_r = {nxt_hw[daw_pkg::Q_RXP], nxt_lw[daw_pkg::Q_RXP]};
	wire alm_rise = |({nxt_alm_p, nxt_alm_r} & ~{alm_p_ff, alm_r_ff});
	wire wrn_rise = |({nxt_wrn_p, nxt_wrn_r} & ~{wrn_p_ff, wrn_r_ff});
	wire nxt_tx_off = soft_dis_ff | tx_dis_pin_i;

	// ------------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------------
	wire [7:0] rt_k = idx - daw_pkg::IDX_RT_FIRST;
	wire [15:0] rt_word = rt_ff[rt_k[3:1]];
	wire [7:0] rt_sel = rt_k[0] ? rt_word[7:0] : rt_word[15:8];
	wire [7:0] thr_sel = thr_ff[idx[5:0]];
	wire [7:0] ctrl_rd = {tx_dis_pin_i, soft_dis_ff, 1'b0, rate_sel_i,
		1'b0, tx_fault_i, rx_los_i, nrdy_ff};
	// Reserved flag bits and unmapped words read as zero.
	wire [7:0] rd_byte =
		hit_thr ? thr_sel :
		hit_rt ? rt_sel :
		(idx == daw_pkg::IDX_CTRL) ? ctrl_rd :
		(idx == daw_pkg::IDX_ALM_P) ? alm_p_ff :
		(idx == daw_pkg::IDX_ALM_R) ? {alm_r_ff, {daw_pkg::RX_RSV_W{1'b0}}} :
		(idx == daw_pkg::IDX_WRN_P) ? wrn_p_ff :
		(idx == daw_pkg::IDX_WRN_R) ? {wrn_r_ff, {daw_pkg::RX_RSV_W{1'b0}}} :
		(idx == daw_pkg::IDX_IRQ_STAT) ? {5'h00, istat} :
		(idx == daw_pkg::IDX_IRQ_MASK) ? {5'h00, imask} : 8'h00;

	// ------------------------------------------------------------------
	// Bus handshake: one wait cycle, then the answer
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus_ff <= daw_pkg::BUS_IDLE;
			rdata_ff <= 32'h0000_0000;
		end else begin
			case (bus_ff)
				daw_pkg::BUS_IDLE: begin
					if (req) begin
						bus_ff <= daw_pkg::BUS_ACK;
						rdata_ff <= {24'h00_0000, rd_byte};
					end
				end
				daw_pkg::BUS_ACK: begin
					bus_ff <= daw_pkg::BUS_IDLE;
				end
				default: begin
					bus_ff <= daw_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	assign avs_readdata_o = rdata_ff;

	// ------------------------------------------------------------------
	// Thresholds and control
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i <= daw_pkg::IDX_THR_LAST; i++) begin
				thr_ff[i] <= daw_pkg::THR_RST;
			end
			soft_dis_ff <= daw_pkg::SOFT_DIS_RST;
		end else begin
			if (wr_thr) begin
				thr_ff[idx[5:0]] <= wdata;
			end
			if (wr_ctrl) begin
				soft_dis_ff <= wdata[daw_pkg::CTL_SOFT_DIS];
			end
		end
	end

	// ------------------------------------------------------------------
	// Measurements and flags
	// ------------------------------------------------------------------
	// Flags lag a new measurement by one cycle so that every flag of a
	// set is taken from the same values, never from a mix of old and new.
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < daw_pkg::NUM_Q; i++) begin
				rt_ff[i] <= daw_pkg::RT_RST;
			end
			nrdy_ff <= 1'b1;
		end else if (meas_upd_i) begin
			rt_ff[0] <= meas_temp_i;
			rt_ff[1] <= meas_vcc_i;
			rt_ff[2] <= meas_bias_i;
			rt_ff[3] <= meas_txp_i;
			rt_ff[4] <= meas_rxp_i;
			nrdy_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alm_p_ff <= 8'h00;
			alm_r_ff <= 2'h0;
			wrn_p_ff <= 8'h00;
			wrn_r_ff <= 2'h0;
			tx_off_ff <= 1'b0;
		end else begin
			alm_p_ff <= nxt_alm_p;
			alm_r_ff <= nxt_alm_r;
			wrn_p_ff <= nxt_wrn_p;
			wrn_r_ff <= nxt_wrn_r;
			tx_off_ff <= nxt_tx_off;
		end
	end

	assign tx_off_o = tx_off_ff;
	// The receiver has no rate choice, so the pin is only reported.
	assign rx_full_bw_o = 1'b1;

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	daw_irq u_irq (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.evt_i({meas_upd_i, wrn_rise, alm_rise}),
		.wr_stat_i(wr_istat),
		.wr_mask_i(wr_imask),
		.wdata_i(wdata),
		.stat_o(istat),
		.mask_o(imask),
		.irq_o(irq_o)
	);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	wire [15:0] th_temp_ha = {thr_ff[daw_pkg::THR_HA], thr_ff[daw_pkg::THR_HA + 1]};
	wire [15:0] th_temp_la = {thr_ff[daw_pkg::THR_LA], thr_ff[daw_pkg::THR_LA + 1]};

	a_tx_off_or: assert property (
		tx_off_o == ($past(soft_dis_ff) | $past(tx_dis_pin_i)))
		else $error("transmitter off state does not follow soft bit or pin");
	a_full_bw_fixed: assert property ($changed(rate_sel_i) |=> rx_full_bw_o)
		else $error("receive bandwidth moved with rate select");
	a_temp_hi_alarm: assert property (
		alm_p_ff[7] == ($signed($past(rt_ff[0])) > $signed($past(th_temp_ha))))
		else $error("temperature high alarm wrong");
	a_temp_lo_alarm: assert property (
		alm_p_ff[6] == ($signed($past(rt_ff[0])) < $signed($past(th_temp_la))))
		else $error("temperature low alarm wrong");
	a_vcc_hi_alarm: assert property (
		meas_upd_i && (meas_vcc_i > {thr_ff[8], thr_ff[9]}) && !wr_thr
		|=> ##1 alm_p_ff[5])
		else $error("supply high alarm not raised");
	a_rx_rsv_zero: assert property (
		avs_read_i && !avs_waitrequest_o && (idx == daw_pkg::IDX_ALM_R)
		|-> avs_readdata_o[5:0] == 6'h00)
		else $error("reserved receive alarm bits not zero");
	a_rx_lo_warn: assert property (
		wrn_r_ff[0] == ($past(rt_ff[4]) < $past({thr_ff[38], thr_ff[39]})))
		else $error("receive low warning wrong");
	a_soft_dis_write: assert property (
		wr_ctrl |=> (soft_dis_ff == $past(wdata[daw_pkg::CTL_SOFT_DIS]))
		##1 (tx_off_o || !$past(soft_dis_ff)))
		else $error("soft disable write not applied");
	a_meas_latch: assert property (
		meas_upd_i |=> (rt_ff[2] == $past(meas_bias_i)) && !nrdy_ff)
		else $error("measurement not captured");
	a_bus_answer: assert property (
		req && !in_ack |=> !avs_waitrequest_o)
		else $error("bus answer late");

	// Each flag is a strict compare of last cycle's value against last cycle's limits.
	a_vcc_lo_alarm: assert property (
		alm_p_ff[4] == ($past(rt_ff[1]) < $past({thr_ff[10], thr_ff[11]})))
		else $error("supply low alarm wrong");
	a_bias_alarms: assert property (
		alm_p_ff[3:2] == {$past(rt_ff[2]) > $past({thr_ff[16], thr_ff[17]}),
		$past(rt_ff[2]) < $past({thr_ff[18], thr_ff[19]})})
		else $error("laser bias alarm flags wrong");
	a_txp_alarms: assert property (
		alm_p_ff[1:0] == {$past(rt_ff[3]) > $past({thr_ff[24], thr_ff[25]}),
		$past(rt_ff[3]) < $past({thr_ff[26], thr_ff[27]})})
		else $error("transmit power alarm flags wrong");
	a_rx_alarms: assert property (
		alm_r_ff == {$past(rt_ff[4]) > $past({thr_ff[32], thr_ff[33]}),
		$past(rt_ff[4]) < $past({thr_ff[34], thr_ff[35]})})
		else $error("receive power alarm flags wrong");
	a_temp_warns: assert property (
		wrn_p_ff[7:6] == {$signed($past(rt_ff[0])) > $signed($past({thr_ff[4], thr_ff[5]})),
		$signed($past(rt_ff[0])) < $signed($past({thr_ff[6], thr_ff[7]}))})
		else $error("temperature warning flags wrong");
	a_vcc_warns: assert property (
		wrn_p_ff[5:4] == {$past(rt_ff[1]) > $past({thr_ff[12], thr_ff[13]}),
		$past(rt_ff[1]) < $past({thr_ff[14], thr_ff[15]})})
		else $error("supply warning flags wrong");
	a_bias_warns: assert property (
		wrn_p_ff[3:2] == {$past(rt_ff[2]) > $past({thr_ff[20], thr_ff[21]}),
		$past(rt_ff[2]) < $past({thr_ff[22], thr_ff[23]})})
		else $error("laser bias warning flags wrong");
	a_txp_warns: assert property (
		wrn_p_ff[1:0] == {$past(rt_ff[3]) > $past({thr_ff[28], thr_ff[29]}),
		$past(rt_ff[3]) < $past({thr_ff[30], thr_ff[31]})})
		else $error("transmit power warning flags wrong");
	a_rx_hi_warn: assert property (
		wrn_r_ff[1] == ($past(rt_ff[4]) > $past({thr_ff[36], thr_ff[37]})))
		else $error("receive high warning wrong");
	a_rx_wrn_rsv: assert property (
		avs_read_i && !avs_waitrequest_o && (idx == daw_pkg::IDX_WRN_R)
		|-> avs_readdata_o[5:0] == 6'h00)
		else $error("reserved receive warning bits not zero");

	// A rising flag must reach the status register even when a clear lands with it.
	a_alarm_sticky: assert property (
		alm_rise |=> istat[daw_pkg::IRQ_ALM])
		else $error("alarm event not recorded");
	a_warn_sticky: assert property (
		wrn_rise |=> istat[daw_pkg::IRQ_WRN])
		else $error("warning event not recorded");
	a_stat_clear: assert property (
		wr_istat && wdata[daw_pkg::IRQ_UPD] && !meas_upd_i |=> !istat[daw_pkg::IRQ_UPD])
		else $error("update status bit not cleared");

	c_write_ctrl: cover property (wr_ctrl && wdata[daw_pkg::CTL_SOFT_DIS]);
	c_alarm_raise: cover property (alm_rise ##[1:20] irq_o);
	c_flag_clear: cover property ($fell(alm_p_ff[7]));
	c_read_flags: cover property (avs_read_i && in_ack && idx == daw_pkg::IDX_WRN_P);
	c_warn_raise: cover property (wrn_rise ##1 istat[daw_pkg::IRQ_WRN]);
endmodule

// file: sim/daw_host.sv
// Host model: a bus master that reads and writes the diagnostic registers.
// Assumes the bench issues one command at a time and waits for done_o.
`timescale 1ns/1ps
module daw_host (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Bench command
	input wire logic go_i,
	input wire logic rd_i,
	input wire logic [7:0] idx_i,
	input wire logic [7:0] wd_i,
	output logic done_o,
	output logic [7:0] rdata_o,
	// Avalon-MM master
	output logic [9:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [31:0] writedata_o,
	input wire logic [31:0] readdata_i,
	input wire logic waitrequest_i
);
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			read_o <= 1'b0;
			write_o <= 1'b0;
			address_o <= 10'h000;
			writedata_o <= 32'h00000000;
			done_o <= 1'b0;
			rdata_o <= 8'h00;
		end else if ((read_o || write_o) && !waitrequest_i) begin
			read_o <= 1'b0;
			write_o <= 1'b0;
			// Released data must not keep looking valid.
			writedata_o <= ~writedata_o;
			rdata_o <= readdata_i[7:0];
			done_o <= 1'b1;
		end else begin
			done_o <= 1'b0;
			if (go_i && !read_o && !write_o) begin
				read_o <= rd_i;
				write_o <= !rd_i;
				address_o <= {idx_i, 2'b00};
				writedata_o <= {24'h000000, wd_i};
			end
		end
	end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the diagnostic flag block.
// Assumes the host model as bus master and a 25 MHz clock.
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------------------------------
	// Stimulus, wiring and counters
	// ----------------------------------------------------------------
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic go = 1'b0;
	logic rd = 1'b0;
	logic [7:0] idx = 8'h00;
	logic [7:0] wd = 8'h00;
	logic upd = 1'b0;
	logic [15:0] mv [5] = '{default: 16'h0000};
	logic pin = 1'b0;
	logic rate = 1'b0;
	logic fault = 1'b0;
	logic los = 1'b0;
	logic done, rreq, wreq, wait_req, tx_off, full_bw, irq;
	logic [7:0] rdat;
	logic [9:0] addr;
	logic [31:0] wdat, rbus;
	logic [15:0] th [5][5];
	logic [15:0] cur [5];
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;

	always #20 sys_clk_i = ~sys_clk_i;

	daw_host u_host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .go_i(go), .rd_i(rd),
		.idx_i(idx), .wd_i(wd), .done_o(done), .rdata_o(rdat), .address_o(addr),
		.read_o(rreq), .write_o(wreq), .writedata_o(wdat), .readdata_i(rbus),
		.waitrequest_i(wait_req));

	daw_flags u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(addr),
		.avs_read_i(rreq), .avs_write_i(wreq), .avs_byteenable_i(4'hf),
		.avs_writedata_i(wdat), .avs_readdata_o(rbus), .avs_waitrequest_o(wait_req),
		.meas_upd_i(upd), .meas_temp_i(mv[0]), .meas_vcc_i(mv[1]), .meas_bias_i(mv[2]),
		.meas_txp_i(mv[3]), .meas_rxp_i(mv[4]), .tx_dis_pin_i(pin), .rate_sel_i(rate),
		.tx_fault_i(fault), .rx_los_i(los), .tx_off_o(tx_off), .rx_full_bw_o(full_bw),
		.irq_o(irq));

	// ----------------------------------------------------------------
	// Reference model and shared tasks
	// ----------------------------------------------------------------
	function automatic logic gt(input int q, input logic [15:0] a, input logic [15:0] b);
		return (q == daw_pkg::Q_TEMP) ? ($signed(a) > $signed(b)) : (a > b);
	endfunction

	function automatic logic [31:0] expf();
		logic [31:0] f;
		f = 32'h00000000;
		for (int q = 0; q < daw_pkg::NUM_Q; q++) begin
			f[31-2*q] = gt(q, cur[q], th[q][0]);
			f[30-2*q] = gt(q, th[q][1], cur[q]);
			f[15-2*q] = gt(q, cur[q], th[q][2]);
			f[14-2*q] = gt(q, th[q][3], cur[q]);
		end
		return f;
	endfunction

	// Levels sit next to each threshold and on both alarm thresholds so strict compares show.
	function automatic logic [15:0] lvl(input int q, input int l);
		case (l)
			1: return th[q][0] + 16'h0001;
			2: return th[q][0];
			3: return th[q][2] + 16'h0001;
			4: return th[q][1] - 16'h0001;
			5: return th[q][3] - 16'h0001;
			6: return th[q][1];
			default: return th[q][4];
		endcase
	endfunction

	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_pin(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic r, input logic [7:0] i, input logic [7:0] w);
		int n;
		n = 0;
		go <= 1'b1;
		rd <= r;
		idx <= i;
		wd <= w;
		@(posedge sys_clk_i);
		go <= 1'b0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (done !== 1'b1 && n < 20);
		if (done !== 1'b1) n_mismatch++;
		@(posedge sys_clk_i);
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] w);
		bus(1'b0, i, w);
	endtask

	task automatic rchk(input logic [7:0] i, input logic [7:0] exp);
		bus(1'b1, i, 8'h00);
		cmp_reg(rdat, exp);
	endtask

	task automatic irq_is(input logic exp);
		@(negedge sys_clk_i);
		cmp_pin(irq, exp);
		@(posedge sys_clk_i);
	endtask

	task automatic meas(input int l, input int all);
		for (int q = 0; q < daw_pkg::NUM_Q; q++) begin
			cur[q] = lvl(q, all ? l : (l + q) % 7);
			mv[q] <= cur[q];
		end
		upd <= 1'b1;
		@(posedge sys_clk_i);
		upd <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask

	task automatic chk_flags();
		logic [31:0] f;
		f = expf();
		rchk(daw_pkg::IDX_ALM_P, f[31:24]);
		rchk(daw_pkg::IDX_ALM_R, f[23:16]);
		rchk(daw_pkg::IDX_WRN_P, f[15:8]);
		rchk(daw_pkg::IDX_WRN_R, f[7:0]);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk(8'h00, daw_pkg::THR_RST);
		rchk(daw_pkg::IDX_CTRL, 8'h01);
		rchk(daw_pkg::IDX_ALM_P, 8'h00);
		rchk(daw_pkg::IDX_IRQ_MASK, daw_pkg::IRQ_MASK_RST);
		@(negedge sys_clk_i);
		cmp_pin(tx_off, 1'b0);
		cmp_pin(full_bw, 1'b1);
		@(posedge sys_clk_i);
		wr(8'h80, 8'h5a);
		rchk(8'h80, 8'h00);
		wr(daw_pkg::IDX_ALM_P, 8'hff);
		rchk(daw_pkg::IDX_ALM_P, 8'h00);
		wr(daw_pkg::IDX_RT_FIRST, 8'h5a);
		rchk(daw_pkg::IDX_RT_FIRST, 8'h00);
	endtask

	task automatic t_flags();
		for (int q = 0; q < daw_pkg::NUM_Q; q++) begin
			for (int k = 0; k < 4; k++) begin
				wr(8'(daw_pkg::THR_STRIDE * q + 2 * k), th[q][k][15:8]);
				wr(8'(daw_pkg::THR_STRIDE * q + 2 * k + 1), th[q][k][7:0]);
			end
		end
		rchk(daw_pkg::IDX_THR_LAST - 8'h01, th[4][3][15:8]);
		rchk(daw_pkg::IDX_THR_LAST, th[4][3][7:0]);
		for (int s = 0; s < 14; s++) begin
			meas(s % 7, s >= 7);
			chk_flags();
			for (int q = 0; q < daw_pkg::NUM_Q; q++) begin
				rchk(daw_pkg::IDX_RT_FIRST + 8'(2 * q), cur[q][15:8]);
				rchk(daw_pkg::IDX_RT_FIRST + 8'(2 * q + 1), cur[q][7:0]);
			end
		end
		th[0][0] = 16'hf500;
		wr(8'h00, 8'hf5);
		chk_flags();
		th[0][0] = 16'h0a00;
		wr(8'h00, 8'h0a);
		chk_flags();
	endtask

	task automatic t_txdis();
		for (int k = 0; k < 4; k++) begin
			pin <= k[1];
			rate <= k[0] ^ k[1];
			fault <= k[0];
			los <= k[1];
			wr(daw_pkg::IDX_CTRL, k[0] ? 8'hff : 8'hbf);
			rchk(daw_pkg::IDX_CTRL, {k[1], k[0], 1'b0, k[0] ^ k[1], 1'b0, k[0], k[1], 1'b0});
			@(negedge sys_clk_i);
			cmp_pin(tx_off, k[0] | k[1]);
			cmp_pin(full_bw, 1'b1);
			@(posedge sys_clk_i);
		end
	endtask

	task automatic t_irq();
		meas(0, 1);
		wr(daw_pkg::IDX_IRQ_STAT, 8'h07);
		rchk(daw_pkg::IDX_IRQ_STAT, 8'h00);
		wr(daw_pkg::IDX_IRQ_MASK, 8'hff);
		rchk(daw_pkg::IDX_IRQ_MASK, 8'h07);
		irq_is(1'b0);
		meas(0, 1);
		rchk(daw_pkg::IDX_IRQ_STAT, 8'h04);
		irq_is(1'b1);
		meas(1, 1);
		rchk(daw_pkg::IDX_IRQ_STAT, 8'h07);
		wr(daw_pkg::IDX_IRQ_STAT, 8'h04);
		rchk(daw_pkg::IDX_IRQ_STAT, 8'h03);
		wr(daw_pkg::IDX_IRQ_MASK, 8'h04);
		irq_is(1'b0);
		wr(daw_pkg::IDX_IRQ_MASK, 8'h02);
		irq_is(1'b1);
		wr(daw_pkg::IDX_IRQ_STAT, 8'h03);
		irq_is(1'b0);
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// The whole run needs about 1200 cycles; the ceiling leaves ample margin.
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		th[0] = '{16'h0a00, 16'hf600, 16'h0500, 16'hfb00, 16'h0000};
		for (int q = 1; q < daw_pkg::NUM_Q; q++) begin
			th[q] = '{16'hc000, 16'h1000, 16'h9000, 16'h3000, 16'h6000};
		end
		repeat (12) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		@(posedge sys_clk_i);
		t_reset();
		t_flags();
		t_txdis();
		t_irq();
		final_report();
	end
endmodule
